/* rtl/sdp_pkg.sv */
// Purpose: Shared constants and types of the pulse-train position input.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes:   Offsets are byte addresses on paddr[7:0].
package sdp_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL        = 8'h00;
  localparam logic [7:0] OFF_NUMER       = 8'h04;
  localparam logic [7:0] OFF_DENOM       = 8'h08;
  localparam logic [7:0] OFF_PERIOD      = 8'h0c;
  localparam logic [7:0] OFF_FE_WINDOW   = 8'h10;
  localparam logic [7:0] OFF_FE_TIMEOUT  = 8'h14;
  localparam logic [7:0] OFF_DEMAND      = 8'h18;
  localparam logic [7:0] OFF_STATUS      = 8'h1c;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h24;
  localparam logic [7:0] OFF_PULSE_TOTAL = 8'h28;
  localparam logic [7:0] OFF_POLE_PAIRS  = 8'h2c;
  localparam logic [7:0] OFF_STEPS_REV   = 8'h30;

  // Control register fields.
  localparam int CTRL_MODE_LSB    = 0;
  localparam int CTRL_SUBMODE_BIT = 8;
  localparam int CTRL_CLOSED_BIT  = 9;

  // Status register fields.
  localparam int STAT_ACTIVE_BIT    = 0;
  localparam int STAT_SUBMODE_BIT   = 1;
  localparam int STAT_CLOSED_BIT    = 2;
  localparam int STAT_FOLLOW_ERR_BIT = 13;

  // Interrupt status and mask fields.
  localparam int IRQ_W            = 3;
  localparam int IRQ_UPDATE_BIT   = 0;
  localparam int IRQ_FOLLOW_BIT   = 1;
  localparam int IRQ_REV_GAP_BIT  = 2;

  // Operating mode selector value that selects pulse-train positioning.
  localparam logic [7:0] MODE_PULSE_TRAIN = 8'hff;

  // Reset values.
  localparam logic [7:0]  RST_MODE       = 8'h00;
  localparam logic [15:0] RST_NUMER      = 16'h0080;
  localparam logic [15:0] RST_DENOM      = 16'h0001;
  localparam logic [15:0] RST_PERIOD     = 16'h0001;
  localparam logic [31:0] RST_FE_WINDOW  = 32'h0000_0100;
  localparam logic [15:0] RST_FE_TIMEOUT = 16'h000a;
  localparam logic [7:0]  RST_POLE_PAIRS = 8'h32;

  // Position units and motor geometry.
  localparam int FULL_STEP_UNITS     = 512;
  localparam int HALF_STEP_UNITS     = 256;
  localparam int STEPS_PER_POLE_PAIR = 4;

  // Timing.
  localparam int CLK_PERIOD_NS     = 50;
  localparam int MS_NS             = 1000000;
  localparam int CLK_CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int REV_GAP_US        = 35;
  localparam int REV_GAP_CYCLES    = (REV_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic {
    pulse_plus_direction_submode,
    split_rotation_pulse_submode
  } sdp_submode_type;

  typedef struct packed {
    logic [7:0]      mode;
    sdp_submode_type submode;
    logic            closed_loop;
    logic [15:0]     numer;
    logic [15:0]     denom;
    logic [15:0]     period;
    logic [31:0]     fe_window;
    logic [15:0]     fe_timeout;
    logic [7:0]      pole_pairs;
  } sdp_cfg_type;

endpackage : sdp_pkg

/* rtl/sdp_pulse_input.sv */
// Purpose: Pulse-train position input: counts pulses, scales them, updates demand per cycle.
// Assumes: pclk at 20 MHz; input pins are asynchronous to pclk.
// Notes:   Registers on APB with zero wait states; one level interrupt output.
//
// The APB register port and the address map are this design's own decisions.

`timescale 1ns/100ps

module sdp_pulse_input #(
  parameter int CYCLES_PER_MS = sdp_pkg::CLK_CYCLES_PER_MS,  // Clock cycles in one millisecond.
  parameter int ACC_W         = 16,                          // Width of the pulse accumulator.
  parameter int NUM_W         = 16                           // Width of numerator and denominator.
) (
  input  wire logic        pclk,                // APB and block clock.
  input  wire logic        presetn,             // Asynchronous reset, active low.
  input  wire logic        psel,                // APB select.
  input  wire logic        penable,             // APB access phase.
  input  wire logic        pwrite,              // APB direction, high for write.
  input  wire logic [7:0]  paddr,               // APB byte address.
  input  wire logic [31:0] pwdata,              // APB write data.
  input  wire logic [3:0]  pstrb,               // APB write byte strobes.
  output logic      [31:0] prdata,              // APB read data.
  output logic             pready,              // APB ready.
  output logic             pslverr,             // APB error on unmapped address.
  input  wire logic        input1_pin,          // Physical input 1, pulse or clockwise.
  input  wire logic        input2_pin,          // Physical input 2, direction or counter-clockwise.
  input  wire logic [31:0] actual_position,     // Measured position from the loop.
  output logic      [31:0] demand_position,     // Demand position, 512 units per full step.
  output logic             demand_update,       // One-cycle strobe when demand is updated.
  output logic             pulse_inputs_claimed, // Inputs 1 and 2 serve the pulse train.
  output logic             following_error,     // Following error level.
  output logic      [15:0] full_steps_per_rev,  // Full steps per mechanical revolution.
  output logic             irq                  // Level interrupt.
);

  localparam int PROD_W = ACC_W + NUM_W + 2;
  localparam int MS_W   = $clog2(CYCLES_PER_MS + 1);
  localparam int GAP_W  = $clog2(sdp_pkg::REV_GAP_CYCLES + 1);
  localparam logic [MS_W-1:0]  MS_LAST  = MS_W'(CYCLES_PER_MS - 1);
  localparam logic [GAP_W-1:0] GAP_DONE = GAP_W'(sdp_pkg::REV_GAP_CYCLES);

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_value,
                                              input logic [31:0] new_value,
                                              input logic [3:0]  strobes);
    logic [31:0] result;
    result = old_value;
    for (int b = 0; b < 4; b++) begin
      if (strobes[b]) begin
        result[b*8 +: 8] = new_value[b*8 +: 8];
      end
    end
    return result;
  endfunction : merge_bytes

  sdp_pkg::sdp_cfg_type        cfg;
  logic [sdp_pkg::IRQ_W-1:0]   irq_status;
  logic [sdp_pkg::IRQ_W-1:0]   irq_mask;
  logic [sdp_pkg::IRQ_W-1:0]   irq_clear_hold;
  logic [1:0]                  sync1;
  logic [1:0]                  sync2;
  logic [1:0]                  sync3;
  logic [1:0]                  level;
  logic signed [ACC_W-1:0]     acc;
  logic signed [ACC_W-1:0]     pulse_total;
  logic signed [NUM_W:0]       residue;
  logic [MS_W-1:0]             ms_count;
  logic [15:0]                 period_count;
  logic [15:0]                 fe_count;
  logic [GAP_W-1:0]            gap_count;
  logic                        fe_raised;

  // APB decode.
  wire        apb_setup   = psel & ~penable;
  wire        apb_access  = psel & penable;
  wire        apb_write   = apb_access & pwrite;
  wire        sel_ctrl    = paddr == sdp_pkg::OFF_CTRL;
  wire        sel_numer   = paddr == sdp_pkg::OFF_NUMER;
  wire        sel_denom   = paddr == sdp_pkg::OFF_DENOM;
  wire        sel_period  = paddr == sdp_pkg::OFF_PERIOD;
  wire        sel_fe_win  = paddr == sdp_pkg::OFF_FE_WINDOW;
  wire        sel_fe_tout = paddr == sdp_pkg::OFF_FE_TIMEOUT;
  wire        sel_demand  = paddr == sdp_pkg::OFF_DEMAND;
  wire        sel_status  = paddr == sdp_pkg::OFF_STATUS;
  wire        sel_irq_st  = paddr == sdp_pkg::OFF_IRQ_STATUS;
  wire        sel_irq_mk  = paddr == sdp_pkg::OFF_IRQ_MASK;
  wire        sel_total   = paddr == sdp_pkg::OFF_PULSE_TOTAL;
  wire        sel_poles   = paddr == sdp_pkg::OFF_POLE_PAIRS;
  wire        sel_steps   = paddr == sdp_pkg::OFF_STEPS_REV;
  wire        addr_hit    = sel_ctrl | sel_numer | sel_denom | sel_period | sel_fe_win |
                            sel_fe_tout | sel_demand | sel_status | sel_irq_st | sel_irq_mk |
                            sel_total | sel_poles | sel_steps;
  wire [31:0] ctrl_word   = {22'h0, cfg.closed_loop, cfg.submode, cfg.mode};
  wire [31:0] next_ctrl   = merge_bytes(ctrl_word, pwdata, pstrb);
  wire [31:0] next_numer  = merge_bytes({16'h0, cfg.numer}, pwdata, pstrb);
  wire [31:0] next_denom  = merge_bytes({16'h0, cfg.denom}, pwdata, pstrb);
  wire [31:0] next_period = merge_bytes({16'h0, cfg.period}, pwdata, pstrb);
  wire [31:0] next_fe_win = merge_bytes(cfg.fe_window, pwdata, pstrb);
  wire [31:0] next_fe_to  = merge_bytes({16'h0, cfg.fe_timeout}, pwdata, pstrb);
  wire [31:0] next_mask   = merge_bytes({29'h0, irq_mask}, pwdata, pstrb);
  wire [31:0] next_poles  = merge_bytes({24'h0, cfg.pole_pairs}, pwdata, pstrb);

  assign pready  = 1'b1;
  assign pslverr = apb_access & ~addr_hit;

  // Mode selection and input routing.
  wire mode_active = cfg.mode == sdp_pkg::MODE_PULSE_TRAIN;
  wire split_mode  = cfg.submode == sdp_pkg::split_rotation_pulse_submode;

  // A level change counts only once the second and third stages agree.
  wire [1:0] pins       = {input2_pin, input1_pin};
  wire [1:0] agree      = ~(sync2 ^ sync3);
  wire [1:0] next_level = (agree & sync3) | (~agree & level);
  wire [1:0] rise       = next_level & ~level;

  // Direction is the accepted level of input 2 at the edge that finds the pulse.
  wire dir_fwd   = level[1];
  wire step_fwd  = mode_active & (split_mode ? rise[0] : (rise[0] & dir_fwd));
  wire step_rev  = mode_active & (split_mode ? rise[1] : (rise[0] & ~dir_fwd));
  wire signed [ACC_W-1:0] step_delta =
    (step_fwd & ~step_rev) ? ACC_W'(1) :
    (step_rev & ~step_fwd) ? -ACC_W'(1) : ACC_W'(0);

  // Cycle timing: a millisecond tick, and the interpolation tick every period.
  wire        ms_tick     = ms_count == MS_LAST;
  wire [15:0] period_last = (cfg.period == 16'h0000) ? 16'h0000 : cfg.period - 16'h0001;
  wire        cycle_tick  = ms_tick & (period_count >= period_last);

  // Scaling keeps the division remainder so no fraction of a pulse is lost.
  wire [NUM_W-1:0]          denom_eff = (cfg.denom == 16'h0000) ? NUM_W'(1) : cfg.denom;
  wire signed [PROD_W-1:0]  numer_s   = $signed(PROD_W'({1'b0, cfg.numer}));
  wire signed [PROD_W-1:0]  denom_s   = $signed(PROD_W'({1'b0, denom_eff}));
  wire signed [PROD_W-1:0]  acc_s     = PROD_W'(acc);
  wire signed [PROD_W-1:0]  res_s     = PROD_W'(residue);
  wire signed [PROD_W-1:0]  scaled    = acc_s * numer_s + res_s;
  wire signed [PROD_W-1:0]  quotient  = scaled / denom_s;
  wire signed [PROD_W-1:0]  remainder = scaled % denom_s;

  // Following error supervision.
  wire signed [31:0] deviation  = $signed(demand_position - actual_position);
  wire [31:0]        dev_abs    = deviation[31] ? 32'(-deviation) : 32'(deviation);
  wire               fe_armed   = mode_active & cfg.closed_loop;
  wire               fe_outside = fe_armed & (dev_abs > cfg.fe_window);
  wire               fe_now     = fe_outside & (fe_count > cfg.fe_timeout);

  // A pulse too soon after a direction change is flagged, not refused.
  wire dir_change = mode_active & ~split_mode & (next_level[1] ^ level[1]);
  wire gap_short  = step_fwd | step_rev ? (~split_mode & (gap_count < GAP_DONE)) : 1'b0;

  wire [sdp_pkg::IRQ_W-1:0] irq_events;
  assign irq_events[sdp_pkg::IRQ_UPDATE_BIT]  = cycle_tick & mode_active;
  assign irq_events[sdp_pkg::IRQ_FOLLOW_BIT]  = fe_now & ~fe_raised;
  assign irq_events[sdp_pkg::IRQ_REV_GAP_BIT] = gap_short;

  wire [31:0] status_word = {18'h0, following_error, 10'h0, cfg.closed_loop,
                             cfg.submode, mode_active};

  logic [31:0] rd_value;
  always_comb begin
    rd_value = 32'h0000_0000;
    unique case (1'b1)
      sel_ctrl:    rd_value = ctrl_word;
      sel_numer:   rd_value = {16'h0, cfg.numer};
      sel_denom:   rd_value = {16'h0, cfg.denom};
      sel_period:  rd_value = {16'h0, cfg.period};
      sel_fe_win:  rd_value = cfg.fe_window;
      sel_fe_tout: rd_value = {16'h0, cfg.fe_timeout};
      sel_demand:  rd_value = demand_position;
      sel_status:  rd_value = status_word;
      sel_irq_st:  rd_value = {29'h0, irq_status};
      sel_irq_mk:  rd_value = {29'h0, irq_mask};
      sel_total:   rd_value = 32'(pulse_total);
      sel_poles:   rd_value = {24'h0, cfg.pole_pairs};
      sel_steps:   rd_value = {16'h0, full_steps_per_rev};
      default:     rd_value = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the setup phase so that prdata comes from a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata         <= 32'h0000_0000;
      irq_clear_hold <= '0;
    end else if (apb_setup) begin
      prdata         <= rd_value;
      irq_clear_hold <= (sel_irq_st & ~pwrite) ? irq_status : '0;
    end
  end

  // Configuration registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.mode        <= sdp_pkg::RST_MODE;
      cfg.submode     <= sdp_pkg::pulse_plus_direction_submode;
      cfg.closed_loop <= 1'b0;
      cfg.numer       <= sdp_pkg::RST_NUMER;
      cfg.denom       <= sdp_pkg::RST_DENOM;
      cfg.period      <= sdp_pkg::RST_PERIOD;
      cfg.fe_window   <= sdp_pkg::RST_FE_WINDOW;
      cfg.fe_timeout  <= sdp_pkg::RST_FE_TIMEOUT;
      cfg.pole_pairs  <= sdp_pkg::RST_POLE_PAIRS;
      irq_mask        <= '0;
    end else if (apb_write) begin
      if (sel_ctrl) begin
        cfg.mode        <= next_ctrl[sdp_pkg::CTRL_MODE_LSB +: 8];
        cfg.submode     <= sdp_pkg::sdp_submode_type'(next_ctrl[sdp_pkg::CTRL_SUBMODE_BIT]);
        cfg.closed_loop <= next_ctrl[sdp_pkg::CTRL_CLOSED_BIT];
      end
      if (sel_numer)   cfg.numer      <= next_numer[NUM_W-1:0];
      if (sel_denom)   cfg.denom      <= next_denom[NUM_W-1:0];
      if (sel_period)  cfg.period     <= next_period[15:0];
      if (sel_fe_win)  cfg.fe_window  <= next_fe_win;
      if (sel_fe_tout) cfg.fe_timeout <= next_fe_to[15:0];
      if (sel_irq_mk)  irq_mask       <= next_mask[sdp_pkg::IRQ_W-1:0];
      if (sel_poles)   cfg.pole_pairs <= next_poles[7:0];
    end
  end

  // Input synchronisers; sync1 feeds sync2 alone.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
      sync3 <= 2'h0;
      level <= 2'h0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
      level <= next_level;
    end
  end

  // Millisecond and interpolation period counters.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_count     <= '0;
      period_count <= 16'h0000;
    end else begin
      ms_count     <= ms_tick ? '0 : ms_count + MS_W'(1);
      if (ms_tick) begin
        period_count <= cycle_tick ? 16'h0000 : period_count + 16'h0001;
      end
    end
  end

  // A pulse found on the boundary edge starts the new cycle's sum.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc         <= '0;
      pulse_total <= '0;
    end else if (!mode_active) begin
      acc         <= '0;
    end else if (cycle_tick) begin
      acc         <= step_delta;
      pulse_total <= acc;
    end else begin
      acc         <= acc + step_delta;
    end
  end

  // Demand position advances once per interpolation cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      demand_position <= 32'h0000_0000;
      residue         <= '0;
      demand_update   <= 1'b0;
    end else begin
      demand_update <= cycle_tick & mode_active;
      if (!mode_active) begin
        residue <= '0;
      end else if (cycle_tick) begin
        demand_position <= demand_position + quotient[31:0];
        residue         <= remainder[NUM_W:0];
      end
    end
  end

  // Following error: milliseconds spent outside the window.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fe_count        <= 16'h0000;
      fe_raised       <= 1'b0;
      following_error <= 1'b0;
    end else begin
      if (!fe_outside) begin
        fe_count <= 16'h0000;
      end else if (ms_tick && fe_count != 16'hffff) begin
        fe_count <= fe_count + 16'h0001;
      end
      fe_raised       <= fe_now;
      following_error <= fe_now;
    end
  end

  // Time since the last direction change, saturating at the required gap.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_count <= GAP_DONE;
    end else if (dir_change) begin
      gap_count <= '0;
    end else if (gap_count != GAP_DONE) begin
      gap_count <= gap_count + GAP_W'(1);
    end
  end

  // Sticky interrupt bits; a new event wins over the clear by a read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~((apb_access & sel_irq_st & ~pwrite) ? irq_clear_hold : '0))
                    | irq_events;
    end
  end

  // Registered outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq                  <= 1'b0;
      pulse_inputs_claimed <= 1'b0;
      full_steps_per_rev   <= 16'h0000;
    end else begin
      irq                  <= |(irq_status & irq_mask);
      pulse_inputs_claimed <= mode_active;
      full_steps_per_rev   <= 16'(sdp_pkg::STEPS_PER_POLE_PAIR) * {8'h00, cfg.pole_pairs};
    end
  end

endmodule : sdp_pulse_input

/* verif/sdp_pulse_input_asserts.sv */
// Purpose: Port checks of the pulse-train position input.
// Assumes: One clock domain; a tick never comes closer than nine clocks.
// Notes:   Bound from the bench top file.
`timescale 1ns/100ps
module sdp_pulse_input_asserts (
  input wire logic        pclk,                 // Clock.
  input wire logic        presetn,              // Reset.
  input wire logic        psel,                 // Select.
  input wire logic        penable,              // Enable.
  input wire logic        pwrite,               // Write.
  input wire logic [31:0] prdata,               // Read data.
  input wire logic        pready,               // Ready.
  input wire logic        pslverr,              // Error.
  input wire logic [31:0] demand_position,      // Demand.
  input wire logic        demand_update,        // Strobe.
  input wire logic        pulse_inputs_claimed, // Mode on.
  input wire logic [15:0] full_steps_per_rev    // Steps.
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_moved; $changed(demand_position); endsequence
  sequence s_quiet; !demand_update [*8]; endsequence
  a_ready_high: assert property (pready) else $error("ready low");
  a_err_in_access: assert property (pslverr |-> psel && penable) else $error("stray error");
  a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read not zero");
  a_moved_then_flag: assert property (s_moved |-> demand_update)
    else $error("no strobe with update");
  a_flag_holds: assert property (demand_update |=> $stable(demand_position))
    else $error("demand moved after strobe");
  a_flag_spacing: assert property (demand_update |=> s_quiet)
    else $error("strobes too close");
  a_idle_still: assert property (!pulse_inputs_claimed [*2] |-> $stable(demand_position))
    else $error("demand moved outside mode");
  a_steps_per_pole: assert property (full_steps_per_rev[1:0] == 2'h0)
    else $error("steps not four per pole pair");
endmodule : sdp_pulse_input_asserts

/* verif/sdp_pulse_input_tb_top.sv */
// Purpose: Self-checking bench of the pulse-train position input.
// Assumes: CYCLES_PER_MS of 20, so a tick comes every 20 clocks.
// Notes:   A monitor judges each read against the oldest queued note.
`timescale 1ns/100ps
module sdp_pulse_input_tb_top;
  logic        pclk = 1'b0, lclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, split = 1'b0, pready, pslverr, upd, claim, ferr, irq, in1, in2;
  logic [7:0]  paddr = 8'h00, n;
  logic [15:0] spr;
  logic [31:0] pwdata = 32'h0, prdata, dem, act = 32'h0, lf = 32'h7197, ed = 32'h0;
  logic [32:0] exp_q[$];
  int          failures = 0, compares = 0;
  always #25 pclk = ~pclk;
  initial #7 forever #200 lclk = ~lclk;
  sdp_pulse_input #(.CYCLES_PER_MS(20)) sdp_pulse_input_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr), .input1_pin(in1),
    .input2_pin(in2), .actual_position(act), .demand_position(dem), .demand_update(upd),
    .pulse_inputs_claimed(claim), .following_error(ferr), .full_steps_per_rev(spr), .irq(irq));
  sdp_pulse_source sdp_pulse_source_inst (.lclk(lclk), .split(split), .in1(in1), .in2(in2));
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nxt
  task automatic chk(input logic [32:0] got, input logic [32:0] want);
    compares++;
    if (got !== want) failures++;
    if (got !== want) $display("BAD %0t got %h want %h", $time, got, want);
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, logic [32:0] e);
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic send(input logic f, input logic [7:0] c);
    sdp_pulse_source_inst.burst(f, c);
    repeat (45) @(posedge pclk);
    $display("burst of %0d pulses done", c);
  endtask : send
  task automatic complete_run();
    $display("%0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // Reads are judged at the access edge, where the note pushed by apb waits.
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite) chk({pslverr, prdata}, exp_q.pop_front());
  initial #2000000 begin
    failures++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h04, 32'h0, 33'h80);
    apb(1'b0, 8'h08, 32'h0, 33'h1);
    apb(1'b0, 8'h30, 32'h0, 33'hc8);
    apb(1'b0, 8'h40, 32'h0, 33'h1_0000_0000);
    send(1'b1, 8'h5);
    chk({1'b0, dem}, 33'h0);
    apb(1'b1, 8'h24, 32'h1, 33'h0);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 8'h00, {23'h0, m[1], 8'hff}, 33'h0);
      split <= m[1];
      lf = nxt(lf);
      n = {5'h0, lf[2:0]} + 8'h1;
      send(m[0], n);
      ed = m[0] ? ed + {17'h0, n, 7'h0} : ed - {17'h0, n, 7'h0};
      chk({1'b0, dem}, {1'b0, ed});
    end
    chk({32'h0, irq}, 33'h1);
    chk({32'h0, claim}, 33'h1);
    chk({17'h0, spr}, 33'hc8);
    apb(1'b1, 8'h24, 32'h0, 33'h0);
    apb(1'b0, 8'h20, 32'h0, 33'h1);
    chk({32'h0, irq}, 33'h0);
    apb(1'b1, 8'h04, 32'h3, 33'h0);
    apb(1'b1, 8'h08, 32'h2, 33'h0);
    send(1'b1, 8'h6);
    chk({1'b0, dem}, {1'b0, ed + 32'h9});
    apb(1'b1, 8'h14, 32'h2, 33'h0);
    apb(1'b1, 8'h00, 32'h2ff, 33'h0);
    act <= ed + 32'h1000;
    repeat (100) @(posedge pclk);
    apb(1'b0, 8'h1c, 32'h0, 33'h2005);
    chk({32'h0, ferr}, 33'h1);
    act <= ed + 32'h9;
    repeat (25) @(posedge pclk);
    chk({32'h0, ferr}, 33'h0);
    apb(1'b1, 8'h2c, 32'h3, 33'h0);
    apb(1'b0, 8'h30, 32'h0, 33'hc);
    chk({17'h0, spr}, 33'hc);
    complete_run();
  end
endmodule : sdp_pulse_input_tb_top
bind sdp_pulse_input sdp_pulse_input_asserts sdp_pulse_input_asserts_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .demand_position(demand_position),
  .demand_update(demand_update), .pulse_inputs_claimed(pulse_inputs_claimed),
  .full_steps_per_rev(full_steps_per_rev));

/* verif/sdp_pulse_source.sv */
// Purpose: Model of the positioning controller driving the two pins.
// Assumes: The bench asks for one burst at a time.
// Notes:   A pulse spans three link clocks, high for one, so it stays under 1 MHz.
`timescale 1ns/100ps
module sdp_pulse_source (
  input  wire logic lclk,  // Link clock.
  input  wire logic split, // Split submode.
  output logic      in1,   // Pulse pin.
  output logic      in2    // Direction pin.
);
  localparam int GAP = 90;  // Ninety link clocks is 36 us, past the reversal guard.
  logic last = 1'b1;
  initial {in1, in2} = 2'h0;
  task automatic burst(input logic fwd, input logic [7:0] cnt);
    @(posedge lclk);
    if (fwd != last || in2 != (!split && fwd)) begin
      in2 = !split && fwd;
      repeat (GAP) @(posedge lclk);
    end
    last = fwd;
    repeat (cnt) begin
      @(posedge lclk);
      in1 = !split || fwd;
      in2 = in2 || (split && !fwd);
      @(posedge lclk);
      in1 = 1'b0;
      in2 = in2 && !split;
      @(posedge lclk);
    end
  endtask : burst
endmodule : sdp_pulse_source
